// ===== hdl/pmc_clock_mode.sv
// Clock source and run/idle/sleep mode control with APB register access
`timescale 1ns/1ps
`include "pmc_regs.svh"
module pmc_clock_mode #(
	parameter int unsigned CPU_READY_CYCLES = 16,
	parameter bit          TWO_SPEED_AT_RST = 1'b0
) (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pri_osc_tick_i,
	input  wire logic        sec_osc_tick_i,
	input  wire logic        int_osc_tick_i,
	input  wire logic        pri_osc_ready_i,
	input  wire logic        sec_osc_running_i,
	input  wire logic        wake_irq_i,
	input  wire logic        watchdog_timeout_i,
	output logic             cpu_clk_en_o,
	output logic             periph_clk_en_o,
	output logic             pri_osc_en_o,
	output logic             sec_osc_en_o,
	output logic             int_rc_en_o,
	output logic             cpu_running_o
);
	if (CPU_READY_CYCLES < 1 || CPU_READY_CYCLES > 65535)
	begin : g_bad_delay
		$error("CPU_READY_CYCLES out of range");
	end

	localparam logic [15:0] DLY_LAST = 16'(CPU_READY_CYCLES - 1);

	pmc_pkg::pmc_state_t r;
	pmc_pkg::pmc_state_t n;
	logic [2:0]          tick;
	logic [2:0]          tick_pin;
	logic                wr_acc;
	logic                rd_setup;
	logic                sleep_cmd;
	logic                wake;
	logic                pri_ready;
	logic                sec_ready;
	logic                mapped;
	logic                old_tick;
	logic                new_tick;
	logic                pri_status;
	logic                sec_running;
	pmc_pkg::pmc_src_t   want;

	assign tick_pin = {int_osc_tick_i, sec_osc_tick_i, pri_osc_tick_i};

	// Oscillators arrive as pins; a rise counts once stages two and three agree, four is the old level
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_tick
			assign tick[gi] = r.tick_sync[gi][1] & r.tick_sync[gi][2] & ~r.tick_sync[gi][3];
		end
	endgenerate

	function automatic logic src_tick(input pmc_pkg::pmc_src_t s, input logic [2:0] t);
		logic v;
		v = 1'b0;
		unique case (s)
			pmc_pkg::PMC_SRC_PRI:  v = t[0];
			pmc_pkg::PMC_SRC_SEC:  v = t[1];
			pmc_pkg::PMC_SRC_INT:  v = t[2];
			pmc_pkg::PMC_SRC_NONE: v = 1'b0;
		endcase
		return v;
	endfunction : src_tick

	assign wr_acc    = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable & ~pwrite;
	assign sleep_cmd = wr_acc & (paddr == `PMC_OFS_CMD) & pwdata[`PMC_BIT_CMD_SLEEP];
	assign wake      = wake_irq_i | watchdog_timeout_i;
	assign mapped    = (paddr == `PMC_OFS_OSC_CTRL) || (paddr == `PMC_OFS_T1_CTRL) ||
	                   (paddr == `PMC_OFS_CFG) || (paddr == `PMC_OFS_CMD) ||
	                   (paddr == `PMC_OFS_STATUS);
	// A crystal in high-speed mode is trusted only after the start-up count
	assign pri_ready = r.pri_rdy_sync[2] & r.pri_rdy_sync[1] &
	                   (~r.cfg[`PMC_BIT_CFG_HS_XTAL] | r.ost_done);
	assign sec_ready = r.secondary_run_mode_sync[2] & r.secondary_run_mode_sync[1];
	assign pri_status  = (r.active == pmc_pkg::PMC_SRC_PRI);
	assign sec_running = (r.active == pmc_pkg::PMC_SRC_SEC);
	assign old_tick    = src_tick(r.active, tick);
	assign new_tick    = src_tick(r.target, tick);

	// Source named by the select field; secondary refused while its oscillator is off
	always_comb
	begin
		unique case (r.sel)
			2'h0: want = pmc_pkg::PMC_SRC_PRI;
			2'h1: want = r.sec_en ? pmc_pkg::PMC_SRC_SEC : r.active;
			default: want = pmc_pkg::PMC_SRC_INT;
		endcase
	end

	always_comb
	begin
		n = r;
		n.cpu_ce = 1'b0;
		n.per_ce = 1'b0;
		n.slverr = 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			n.tick_sync[i] = {r.tick_sync[i][2:0], tick_pin[i]};
		end
		n.pri_rdy_sync = {r.pri_rdy_sync[1:0], pri_osc_ready_i};
		n.secondary_run_mode_sync = {r.secondary_run_mode_sync[1:0], sec_osc_running_i};

		if (wr_acc && paddr == `PMC_OFS_OSC_CTRL)
		begin
			n.idle_en = pwdata[`PMC_BIT_IDLE_EN];
			n.sel     = pwdata[`PMC_BIT_SEL_LO +: 2];
		end
		if (wr_acc && paddr == `PMC_OFS_T1_CTRL)
			n.sec_en = pwdata[`PMC_BIT_SEC_OSC_EN];
		if (wr_acc && paddr == `PMC_OFS_CFG)
			n.cfg = pwdata[4:0];
		if (rd_setup)
		begin
			n.prdata = 32'h0;
			unique case (paddr)
				`PMC_OFS_OSC_CTRL:
				begin
					n.prdata[`PMC_BIT_IDLE_EN]     = r.idle_en;
					n.prdata[`PMC_BIT_PRI_STATUS]  = pri_status;
					n.prdata[`PMC_BIT_SEL_LO +: 2] = r.sel;
				end
				`PMC_OFS_T1_CTRL:
				begin
					n.prdata[`PMC_BIT_SEC_RUNNING] = sec_running;
					n.prdata[`PMC_BIT_SEC_OSC_EN]  = r.sec_en;
				end
				`PMC_OFS_CFG:    n.prdata[4:0] = r.cfg;
				`PMC_OFS_STATUS: n.prdata[9:0] = {r.st, r.active, r.ost_done, pri_ready};
				default:         n.prdata = 32'h0;
			endcase
		end
		if (psel && !penable)
			n.slverr = ~mapped;

		// Start-up timer restarts whenever the primary oscillator has been stopped
		if (!r.pri_on)
		begin
			n.ost_cnt  = 11'h0;
			n.ost_done = 1'b0;
		end
		else if (!r.ost_done && tick[0])
		begin
			n.ost_cnt  = r.ost_cnt + 11'h1;
			n.ost_done = (r.ost_cnt == `PMC_OST_CYCLES - 11'h1);
		end

		unique case (r.st)
			pmc_pkg::PMC_RUN:
			begin
				n.cpu_ce = old_tick;
				n.per_ce = old_tick;
				if (sleep_cmd)
				begin
					// Mode taken from the enables as they stand at this command
					if (r.idle_en)
						n.st = pmc_pkg::PMC_IDLE;
					else
					begin
						// Deep sleep is not served here and falls back to plain sleep
						n.st     = pmc_pkg::PMC_SLEEP;
						n.active = pmc_pkg::PMC_SRC_NONE;
						n.cpu_ce = 1'b0;
						n.per_ce = 1'b0;
					end
				end
				else if (want != r.active)
				begin
					// Old source keeps clocking only while a primary target is not yet ready; the switch then gates both enables
					if ((want != pmc_pkg::PMC_SRC_PRI) || pri_ready)
					begin
						n.st     = pmc_pkg::PMC_SWITCH;
						n.target = want;
						n.sw_new = (r.active == pmc_pkg::PMC_SRC_NONE);
						n.sw_cnt = 2'h0;
					end
				end
			end
			pmc_pkg::PMC_SWITCH:
			begin
				// Both enables stay low so no truncated pulse leaves the block
				if (!r.sw_new)
				begin
					if (old_tick)
					begin
						n.sw_cnt = r.sw_cnt + 2'h1;
						if (r.sw_cnt == `PMC_SW_OLD_TICKS - 2'h1)
						begin
							n.sw_new = 1'b1;
							n.sw_cnt = 2'h0;
						end
					end
				end
				else if (new_tick)
				begin
					n.sw_cnt = r.sw_cnt + 2'h1;
					if (r.sw_cnt == `PMC_SW_NEW_TICKS - 2'h1)
					begin
						n.active = r.target;
						n.st     = pmc_pkg::PMC_RUN;
						n.sw_new = 1'b0;
						n.sw_cnt = 2'h0;
					end
				end
			end
			pmc_pkg::PMC_IDLE:
			begin
				n.per_ce = old_tick;
				if (wake)
				begin
					n.st      = pmc_pkg::PMC_CPUDLY;
					n.dly_cnt = 16'h0;
				end
			end
			pmc_pkg::PMC_SLEEP:
			begin
				if (wake)
				begin
					if (r.cfg[`PMC_BIT_CFG_TWO_SPEED] || r.cfg[`PMC_BIT_CFG_FAILSAFE])
					begin
						n.active  = pmc_pkg::PMC_SRC_INT;
						n.st      = pmc_pkg::PMC_CPUDLY;
						n.dly_cnt = 16'h0;
					end
					else
					begin
						n.target = want;
						n.st     = pmc_pkg::PMC_WAKEW;
					end
				end
			end
			pmc_pkg::PMC_WAKEW:
			begin
				if ((r.target == pmc_pkg::PMC_SRC_PRI && pri_ready) ||
				    (r.target == pmc_pkg::PMC_SRC_SEC && sec_ready) ||
				    (r.target == pmc_pkg::PMC_SRC_INT))
				begin
					n.active  = r.target;
					n.st      = pmc_pkg::PMC_CPUDLY;
					n.dly_cnt = 16'h0;
				end
			end
			pmc_pkg::PMC_CPUDLY:
			begin
				n.per_ce  = old_tick;
				n.dly_cnt = r.dly_cnt + 16'h1;
				if (r.dly_cnt == DLY_LAST)
					n.st = pmc_pkg::PMC_RUN;
			end
			default:
			begin
				n.st = pmc_pkg::PMC_RUN;
			end
		endcase

		// Primary runs while it drives, is wanted outside idle and sleep, or sits as a switch target
		n.pri_on = (n.st != pmc_pkg::PMC_SLEEP) &&
		           ((n.active == pmc_pkg::PMC_SRC_PRI) ||
		            ((n.st != pmc_pkg::PMC_IDLE) && (r.sel == 2'h0)) ||
		            (n.target == pmc_pkg::PMC_SRC_PRI &&
		             (n.st == pmc_pkg::PMC_SWITCH || n.st == pmc_pkg::PMC_WAKEW)));
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			r.st           <= pmc_pkg::PMC_RUN;
			r.active       <= TWO_SPEED_AT_RST ? pmc_pkg::PMC_SRC_INT : pmc_pkg::PMC_SRC_PRI;
			r.target       <= pmc_pkg::PMC_SRC_PRI;
			r.sw_new       <= 1'b0;
			r.sw_cnt       <= 2'h0;
			r.sel          <= `PMC_RST_SEL;
			r.idle_en      <= `PMC_RST_IDLE_EN;
			r.sec_en       <= 1'b0;
			r.cfg          <= {4'(`PMC_RST_CFG), TWO_SPEED_AT_RST};
			r.tick_sync    <= '0;
			r.pri_rdy_sync <= 3'h0;
			r.secondary_run_mode_sync <= 3'h0;
			r.ost_cnt      <= 11'h0;
			r.ost_done     <= 1'b0;
			r.dly_cnt      <= 16'h0;
			r.pri_on       <= 1'b1;
			r.cpu_ce       <= 1'b0;
			r.per_ce       <= 1'b0;
			r.prdata       <= 32'h0;
			r.slverr       <= 1'b0;
		end
		else
		begin
			r <= n;
		end
	end

	assign prdata          = r.prdata;
	assign pready          = 1'b1;
	assign pslverr         = psel & penable & r.slverr;
	assign cpu_clk_en_o    = r.cpu_ce;
	assign periph_clk_en_o = r.per_ce;
	assign pri_osc_en_o    = r.pri_on;
	assign sec_osc_en_o    = r.sec_en;
	// Internal RC is kept for the watchdog and the fail-safe monitor in every mode
	assign int_rc_en_o     = (r.st != pmc_pkg::PMC_SLEEP && r.active == pmc_pkg::PMC_SRC_INT) ||
	                         (r.st == pmc_pkg::PMC_SWITCH && r.target == pmc_pkg::PMC_SRC_INT) ||
	                         r.cfg[`PMC_BIT_CFG_WATCHDOG] || r.cfg[`PMC_BIT_CFG_FAILSAFE] ||
	                         r.cfg[`PMC_BIT_CFG_TWO_SPEED];
	assign cpu_running_o   = (r.st == pmc_pkg::PMC_RUN);

	a_run_both_clocks: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$past(r.st == pmc_pkg::PMC_RUN) && $past(old_tick) && r.st != pmc_pkg::PMC_SWITCH &&
		r.st != pmc_pkg::PMC_SLEEP |-> cpu_clk_en_o && periph_clk_en_o)
		else $error("run mode did not clock both cpu and peripherals");

	a_idle_cpu_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$past(r.st == pmc_pkg::PMC_IDLE) |-> !cpu_clk_en_o && $stable(r.active))
		else $error("cpu clocked or source changed in idle");

	a_sleep_status_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		r.st == pmc_pkg::PMC_SLEEP |-> !pri_status && !sec_running && !pri_osc_en_o
		&& !periph_clk_en_o)
		else $error("status or clocks active in sleep");

	a_sec_needs_enable: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$changed(r.active) && r.active == pmc_pkg::PMC_SRC_SEC |-> $past(r.sec_en, 2))
		else $error("secondary source taken while its oscillator was disabled");

	a_switch_gated: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$past(r.st == pmc_pkg::PMC_SWITCH) |-> !cpu_clk_en_o && !periph_clk_en_o)
		else $error("clock pulse escaped during a switch");

	a_switch_length: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$past(r.st == pmc_pkg::PMC_SWITCH) && r.st == pmc_pkg::PMC_RUN
		|-> $past(r.sw_new) && $past(r.sw_cnt) == 2'h2)
		else $error("switch completed with wrong tick count");

	a_cpu_ready_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$past(r.st == pmc_pkg::PMC_CPUDLY) && r.st == pmc_pkg::PMC_RUN
		|-> $past(r.dly_cnt) == DLY_LAST)
		else $error("cpu resumed before the ready delay elapsed");

	a_ost_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(r.ost_done) |-> r.ost_cnt == `PMC_OST_CYCLES)
		else $error("start-up timer finished at the wrong count");

	a_sel_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$changed(r.sel) || $changed(r.idle_en)
		|-> $past(wr_acc) && $past(paddr) == `PMC_OFS_OSC_CTRL)
		else $error("select or idle enable changed without a write");

	a_pri_wait_ready: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(r.st == pmc_pkg::PMC_SWITCH) && r.target == pmc_pkg::PMC_SRC_PRI
		|-> $past(pri_ready))
		else $error("switch to primary began before it was ready");
endmodule : pmc_clock_mode

// ===== hdl/pmc_pkg.sv
// Types of the power-managed clock mode control
package pmc_pkg;
	typedef enum logic [5:0] {
		PMC_RUN    = 6'h01,
		PMC_SWITCH = 6'h02,
		PMC_IDLE   = 6'h04,
		PMC_SLEEP  = 6'h08,
		PMC_WAKEW  = 6'h10,
		PMC_CPUDLY = 6'h20
	} pmc_mode_t;
	typedef enum logic [1:0] {
		PMC_SRC_PRI  = 2'h0,
		PMC_SRC_SEC  = 2'h1,
		PMC_SRC_NONE = 2'h2,
		PMC_SRC_INT  = 2'h3
	} pmc_src_t;
	typedef struct packed {
		pmc_mode_t       st;
		pmc_src_t        active;
		pmc_src_t        target;
		logic            sw_new;
		logic [1:0]      sw_cnt;
		logic [1:0]      sel;
		logic            idle_en;
		logic            sec_en;
		logic [4:0]      cfg;
		logic [2:0][3:0] tick_sync;
		logic [2:0]      pri_rdy_sync;
		logic [2:0]      secondary_run_mode_sync;
		logic [10:0]     ost_cnt;
		logic            ost_done;
		logic [15:0]     dly_cnt;
		logic            pri_on;
		logic            cpu_ce;
		logic            per_ce;
		logic [31:0]     prdata;
		logic            slverr;
	} pmc_state_t;
endpackage : pmc_pkg

// ===== hdl/pmc_regs.svh
// Register offsets, field positions, reset values and timing counts of the clock mode control
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_OFS_OSC_CTRL      12'h000
`define PMC_OFS_T1_CTRL       12'h004
`define PMC_OFS_CFG           12'h008
`define PMC_OFS_CMD           12'h00c
`define PMC_OFS_STATUS        12'h010
`define PMC_BIT_IDLE_EN       7
`define PMC_BIT_PRI_STATUS    3
`define PMC_BIT_SEL_LO        0
`define PMC_BIT_SEC_RUNNING   6
`define PMC_BIT_SEC_OSC_EN    3
`define PMC_BIT_CFG_TWO_SPEED 0
`define PMC_BIT_CFG_FAILSAFE  1
`define PMC_BIT_CFG_WATCHDOG  2
`define PMC_BIT_CFG_HS_XTAL   3
`define PMC_BIT_CFG_DEEP_EN   4
`define PMC_BIT_CMD_SLEEP     0
`define PMC_RST_SEL           2'h0
`define PMC_RST_IDLE_EN       1'h0
`define PMC_RST_CFG           5'h00
`define PMC_OST_CYCLES        11'h400
`define PMC_SW_OLD_TICKS      2'h2
`define PMC_SW_NEW_TICKS      2'h3
`endif

// ===== verification/pmc_osc_model.sv
// Behavioural oscillators standing on the far side of the clock mode control
`timescale 1ns/1ps
module pmc_osc_model (
	input  wire logic pri_en_i,
	input  wire logic sec_en_i,
	input  wire logic sec_stall_i,
	output logic      pri_tick_o,
	output logic      sec_tick_o,
	output logic      int_tick_o,
	output logic      pri_ready_o,
	output logic      sec_running_o
);
	int pri_cnt = 0;
	initial
	begin
		pri_tick_o = 1'b0;
		sec_tick_o = 1'b0;
		int_tick_o = 1'b0;
	end
	// Half periods unrelated to the system clock, so edges drift across its sampling points
	always #101 pri_tick_o = pri_en_i & ~pri_tick_o;
	always #353 sec_tick_o = sec_en_i & ~sec_stall_i & ~sec_tick_o;
	always #151 int_tick_o = ~int_tick_o;
	// A stopped crystal has to warm up again from zero
	always @(posedge pri_tick_o or negedge pri_en_i)
	begin
		if (!pri_en_i)
			pri_cnt <= 0;
		else if (pri_cnt < 20)
			pri_cnt <= pri_cnt + 1;
	end
	assign pri_ready_o   = pri_en_i && (pri_cnt >= 20);
	assign sec_running_o = sec_en_i & ~sec_stall_i;
endmodule : pmc_osc_model

// ===== verification/tb_top.sv
// Self-checking bench for the clock mode control
`timescale 1ns/1ps
`include "pmc_regs.svh"
module tb_top;
	localparam int          CRC     = 4;
	localparam logic [11:0] OSC     = `PMC_OFS_OSC_CTRL;
	localparam logic [11:0] T1      = `PMC_OFS_T1_CTRL;
	localparam logic [11:0] CFG     = `PMC_OFS_CFG;
	localparam logic [11:0] CMD     = `PMC_OFS_CMD;
	localparam logic [11:0] STA     = `PMC_OFS_STATUS;
	localparam logic [7:0]  RUN_PRI = {pmc_pkg::PMC_RUN, pmc_pkg::PMC_SRC_PRI};
	localparam logic [7:0]  RUN_SEC = {pmc_pkg::PMC_RUN, pmc_pkg::PMC_SRC_SEC};
	localparam logic [7:0]  RUN_INT = {pmc_pkg::PMC_RUN, pmc_pkg::PMC_SRC_INT};
	localparam logic [7:0]  SW_PRI  = {pmc_pkg::PMC_SWITCH, pmc_pkg::PMC_SRC_PRI};
	localparam logic [7:0]  IDL_SEC = {pmc_pkg::PMC_IDLE, pmc_pkg::PMC_SRC_SEC};
	localparam logic [7:0]  IDL_PRI = {pmc_pkg::PMC_IDLE, pmc_pkg::PMC_SRC_PRI};
	localparam logic [7:0]  SLP_NON = {pmc_pkg::PMC_SLEEP, pmc_pkg::PMC_SRC_NONE};
	typedef struct packed
	{
		logic [11:0] addr;
		logic        we;
		logic [31:0] wdata;
		logic [31:0] mask;
		logic [31:0] exp;
		logic        err;
	} pmc_row_t;
	logic        clk_i     = 1'b0;
	logic        rst_b_i   = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [11:0] paddr     = 12'h000;
	logic [31:0] pwdata    = 32'h0;
	logic        wake_irq  = 1'b0;
	logic        wdog_to   = 1'b0;
	logic        sec_stall = 1'b0;
	logic [31:0] prdata;
	logic [31:0] q;
	logic        pready, pslverr, e, pri_tick, sec_tick, int_tick, pri_rdy, secondary_run_mode;
	logic        cpu_ce, per_ce, pri_en, sec_en, int_en, cpu_run;
	int          n_fail = 0, check_count = 0, cyc = 0, cpu_n = 0, per_n = 0, t0, c0, p0;
	pmc_row_t    rows [5] = '{
		'{OSC, 1'b0, 32'h0, 32'h8b, 32'h08, 1'b0},
		'{T1, 1'b0, 32'h0, 32'h48, 32'h00, 1'b0},
		'{STA, 1'b1, 32'hffff, 32'h3fc, 32'h10, 1'b0},
		'{CFG, 1'b1, 32'h04, 32'h1f, 32'h04, 1'b0},
		'{12'h020, 1'b1, 32'h5a, 32'hffffffff, 32'h0, 1'b1}
	};
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		cpu_n <= cpu_n + int'(cpu_ce === 1'b1);
		per_n <= per_n + int'(per_ce === 1'b1);
	end
	pmc_clock_mode #(.CPU_READY_CYCLES(CRC), .TWO_SPEED_AT_RST(1'b0)) u_pmc_clock_mode (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pri_osc_tick_i(pri_tick), .sec_osc_tick_i(sec_tick), .int_osc_tick_i(int_tick),
		.pri_osc_ready_i(pri_rdy), .sec_osc_running_i(secondary_run_mode), .wake_irq_i(wake_irq),
		.watchdog_timeout_i(wdog_to), .cpu_clk_en_o(cpu_ce), .periph_clk_en_o(per_ce),
		.pri_osc_en_o(pri_en), .sec_osc_en_o(sec_en), .int_rc_en_o(int_en),
		.cpu_running_o(cpu_run));
	pmc_osc_model u_pmc_osc_model (
		.pri_en_i(pri_en), .sec_en_i(sec_en), .sec_stall_i(sec_stall),
		.pri_tick_o(pri_tick), .sec_tick_o(sec_tick), .int_tick_o(int_tick),
		.pri_ready_o(pri_rdy), .sec_running_o(secondary_run_mode));
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		check_count++;
		if (got !== want)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge clk_i);
			if (pready === 1'b1)
				break;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16)
		begin
			n_fail++;
			tally_and_finish();
		end
	endtask : apb
	task automatic wait_st(input logic [7:0] st, input int bound);
		int i;
		for (i = 0; i < bound; i++)
		begin
			apb(STA, 1'b0, 32'h0);
			if (q[9:2] === st)
				break;
		end
		chk(32'(q[9:2]), 32'(st));
		if (q[9:2] !== st)
			tally_and_finish();
	endtask : wait_st
	// Pulses a wake source and counts edges until the CPU runs again
	task automatic wake(input logic wd, input int hi);
		int i;
		@(posedge clk_i);
		wake_irq <= ~wd;
		wdog_to <= wd;
		@(posedge clk_i);
		wake_irq <= 1'b0;
		wdog_to <= 1'b0;
		for (i = 0; i < 500 && cpu_run !== 1'b1; i++)
			@(posedge clk_i);
		chk(32'(i >= CRC && i <= hi), 32'h1);
		if (i == 500)
			tally_and_finish();
	endtask : wake
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		foreach (rows[k])
		begin
			if (rows[k].we)
				apb(rows[k].addr, 1'b1, rows[k].wdata);
			apb(rows[k].addr, 1'b0, 32'h0);
			chk(q & rows[k].mask, rows[k].exp);
			chk(32'(e), 32'(rows[k].err));
		end
		apb(OSC, 1'b1, 32'h01);
		repeat (8)
		begin
			apb(STA, 1'b0, 32'h0);
			chk(32'(q[9:2]), 32'(RUN_PRI));
		end
		sec_stall <= 1'b1;
		apb(T1, 1'b1, 32'h08);
		wait_st(SW_PRI, 40);
		c0 = cpu_n;
		repeat (8) apb(STA, 1'b0, 32'h0);
		chk(32'(q[9:2]), 32'(SW_PRI));
		chk(cpu_n - c0, 32'h0);
		sec_stall <= 1'b0;
		wait_st(RUN_SEC, 60);
		apb(T1, 1'b0, 32'h0);
		chk(q & 32'h48, 32'h48);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h08, 32'h0);
		chk(32'(pri_en), 32'h0);
		apb(OSC, 1'b1, 32'h81);
		apb(CMD, 1'b1, 32'h01);
		wait_st(IDL_SEC, 4);
		c0 = cpu_n;
		p0 = per_n;
		repeat (10) apb(T1, 1'b0, 32'h0);
		chk(q & 32'h40, 32'h40);
		chk(32'(per_n > p0), 32'h1);
		wake(1'b0, CRC + 2);
		chk(cpu_n - c0, 32'h0);
		wait_st(RUN_SEC, 2);
		apb(OSC, 1'b1, 32'h80);
		wait_st(RUN_PRI, 150);
		apb(T1, 1'b0, 32'h0);
		chk(q & 32'h48, 32'h08);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h8b, 32'h88);
		apb(CMD, 1'b1, 32'h01);
		wait_st(IDL_PRI, 4);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h08, 32'h08);
		chk(32'({pri_en, sec_en}), 32'h3);
		wake(1'b1, CRC + 2);
		wait_st(RUN_PRI, 2);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h8b, 32'h88);
		apb(OSC, 1'b1, 32'h00);
		apb(CMD, 1'b1, 32'h01);
		wait_st(SLP_NON, 4);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h08, 32'h0);
		apb(T1, 1'b0, 32'h0);
		chk(q & 32'h40, 32'h0);
		chk(32'({pri_en, sec_en, int_en}), 32'h3);
		wake(1'b0, 400);
		wait_st(RUN_PRI, 2);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h8b, 32'h08);
		t0 = cyc;
		apb(OSC, 1'b1, 32'h03);
		wait_st(RUN_INT, 20);
		chk(32'(cyc - t0 >= 16 && cyc - t0 <= 52), 32'h1);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h08, 32'h0);
		chk(32'(pri_en), 32'h0);
		apb(CFG, 1'b1, 32'h0c);
		t0 = cyc;
		c0 = cpu_n;
		p0 = per_n;
		apb(OSC, 1'b1, 32'h00);
		repeat (300) apb(STA, 1'b0, 32'h0);
		chk(32'(q[9:2]), 32'(RUN_INT));
		chk(32'(cpu_n > c0 && per_n > p0), 32'h1);
		wait_st(RUN_PRI, 1500);
		chk(32'(cyc - t0 >= 4096), 32'h1);
		chk(32'(int_en), 32'h1);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h8b, 32'h08);
		apb(STA, 1'b0, 32'h0);
		chk(q & 32'h3fc, 32'h10);
		apb(CFG, 1'b1, 32'h02);
		apb(CMD, 1'b1, 32'h01);
		wait_st(SLP_NON, 4);
		wake(1'b0, CRC + 2);
		wait_st(RUN_INT, 2);
		chk(32'(int_en), 32'h1);
		wait_st(RUN_PRI, 100);
		apb(OSC, 1'b0, 32'h0);
		chk(q & 32'h8b, 32'h08);
		tally_and_finish();
	end
endmodule : tb_top
